// ---- core/acr_clock_divider.sv ----
`timescale 1ns/1ns
`default_nettype none

module acr_clock_divider
  import acr_pkg::*;
#(
  parameter int DIV_WIDTH = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [DIV_WIDTH-1:0] divider,
  // conversion clock tick
  output logic convTick
);

  acr_div_type q, d;

  always_comb begin
    d = q;
    // period is divider plus one system clocks
    d.tick = run && (q.cnt == divider); // RULE1
    if (!run || q.cnt == divider) begin
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // with divider zero the last trial's tick would leak into the idle cycle
  assign convTick = q.tick && run; // RULE1

  // helper: cycles since the previous tick
  logic [5:0] gapQ;
  logic gapValidQ;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gapQ <= 6'h00;
      gapValidQ <= 1'b0;
    end else if (q.tick) begin
      gapQ <= 6'h00;
      gapValidQ <= run;
    end else begin
      gapQ <= gapQ + 6'h01;
      if (!run || divider != $past(divider)) begin
        gapValidQ <= 1'b0;
      end
    end
  end

  property p_tick_period;
    @(posedge clk) disable iff (!rst_b)
      (q.tick && gapValidQ && run) |-> (gapQ == {1'b0, divider});
  endproperty
  a_tick_period: assert property (p_tick_period) // RULE1
    else $error("conversion tick period differs from divider plus one");

endmodule

`default_nettype wire

// ---- core/acr_config.sv ----
// Notes on behaviour
// RULE1: conversion clock is system clock over field+1
// RULE2: software keeps divider nonzero with memory power control
// RULE3: justify bit selects right or left placement
// RULE4: justify bit ignored in eight-bit mode
// RULE5: resolution bit zero gives ten bits
// RULE6: gain bit zero halves input, one unity
// RULE7: eight-bit mode: eight MSBs, two fewer clocks
// RULE8: ten-bit unsigned result, unused bits cleared
`timescale 1ns/1ns
`default_nettype none
`include "acr_consts.svh"

module acr_config
  import acr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // special function register access
  input wire acr_sfr_type sfrBus,
  output logic [7:0] sfrRdata,
  // configuration outputs to the analog side and sequencing
  output acr_cfg_type cfgOut,
  output logic conversionClockTick,
  // conversion control
  input wire logic convStart,
  input wire logic compBit,
  output logic [9:0] sarTrial,
  output logic convBusy,
  output logic convDone,
  // result bytes
  output acr_result_type result
);

  localparam acr_core_type CoreReset = '{
    cfg: acr_cfg_type'(`ACR_CFG_RESET),
    rdata: 8'h00,
    state: ACR_IDLE,
    bitIdx: 4'h0,
    eightBit: 1'b0,
    leftJustify: 1'b0,
    trial: 10'h000,
    code: 10'h000,
    result: 16'h0000,
    done: 1'b0
  };

  acr_core_type q, d;
  logic convTick;
  logic [9:0] decided;

  function automatic logic cfgHit(input acr_sfr_type bus);
    cfgHit = (bus.addr == `ACR_CFG_ADDR);
  endfunction

  function automatic logic [3:0] lastBit(input logic eight);
    lastBit = eight ? `ACR_LAST_BIT_8 : `ACR_LAST_BIT_10;
  endfunction

  // place a finished code into the two result bytes
  function automatic acr_result_type formatResult(
    input logic [9:0] code,
    input logic eight,
    input logic left
  );
    acr_result_type r;
    if (eight) begin
      // only the high byte carries data; justify is moot
      r.resultHighByte = code[9:2]; // RULE4 RULE7
      r.resultLowByte = 8'h00;
    end else if (left) begin
      r.resultHighByte = code[9:2]; // RULE3
      r.resultLowByte = {code[1:0], 6'h00}; // RULE8
    end else begin
      r.resultHighByte = {6'h00, code[9:8]}; // RULE3 RULE8
      r.resultLowByte = code[7:0];
    end
    formatResult = r;
  endfunction

  acr_clock_divider #(
    .DIV_WIDTH(5)
  ) u_divider (
    .clk(clk),
    .rst_b(rst_b),
    .run(q.state == ACR_CONVERT),
    .divider(q.cfg.conversionClockDivider),
    .convTick(convTick)
  );

  always_comb begin
    d = q;
    decided = q.trial;
    decided[q.bitIdx] = compBit;
    d.done = 1'b0;
    // read returns the value held before any same-cycle write
    d.rdata = (sfrBus.rd && cfgHit(sfrBus)) ? q.cfg : 8'h00;
    if (sfrBus.wr && cfgHit(sfrBus)) begin
      d.cfg = acr_cfg_type'(sfrBus.wdata); // RULE1 RULE6
    end
    case (q.state)
      ACR_IDLE: begin
        if (convStart) begin
          // mode is frozen so a write mid-conversion cannot tear it
          d.state = ACR_CONVERT;
          d.eightBit = q.cfg.eightBitResolutionEnable; // RULE5
          d.leftJustify = q.cfg.leftJustifySelect;
          d.trial = `ACR_FIRST_TRIAL;
          d.bitIdx = `ACR_TOP_BIT;
        end
      end
      ACR_CONVERT: begin
        if (convTick) begin
          d.trial = decided;
          if (q.bitIdx == lastBit(q.eightBit)) begin
            // eight-bit stops two bit trials early
            d.state = ACR_IDLE; // RULE7
            d.code = decided;
            d.result = formatResult(decided, q.eightBit,
                                    q.leftJustify); // RULE8
            d.done = 1'b1;
          end else begin
            d.bitIdx = q.bitIdx - 4'h1;
            d.trial[q.bitIdx - 4'h1] = 1'b1;
          end
        end
      end
      default: begin
        d.state = ACR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= CoreReset;
    end else begin
      q <= d;
    end
  end

  assign sfrRdata = q.rdata;
  // gain bit drives the input stage directly: 0 half, 1 unity
  assign cfgOut = q.cfg; // RULE6
  assign conversionClockTick = convTick;
  assign sarTrial = q.trial;
  assign convBusy = (q.state == ACR_CONVERT);
  assign convDone = q.done;
  assign result = q.result;

  // helper: bit trials taken in the running conversion
  logic [3:0] stepCountQ;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stepCountQ <= 4'h0;
    end else if (q.state == ACR_IDLE && convStart) begin
      stepCountQ <= 4'h0;
    end else if (q.state == ACR_CONVERT && convTick) begin
      stepCountQ <= stepCountQ + 4'h1;
    end
  end

  property p_right_justify;
    @(posedge clk) disable iff (!rst_b)
      (q.done && !q.eightBit && !q.leftJustify) |->
        ({q.result.resultHighByte[1:0], q.result.resultLowByte}
          == q.code);
  endproperty
  a_right_justify: assert property (p_right_justify) // RULE3
    else $error("right-justified result does not match code");

  property p_left_justify;
    @(posedge clk) disable iff (!rst_b)
      (q.done && !q.eightBit && q.leftJustify) |->
        ({q.result.resultHighByte, q.result.resultLowByte[7:6]}
          == q.code);
  endproperty
  a_left_justify: assert property (p_left_justify) // RULE3
    else $error("left-justified result does not match code");

  property p_eight_ignores_justify;
    @(posedge clk) disable iff (!rst_b)
      (q.done && q.eightBit) |->
        (q.result.resultHighByte == q.code[9:2] &&
         q.result.resultLowByte == 8'h00);
  endproperty
  a_eight_ignores_justify: assert property (p_eight_ignores_justify) // RULE4
    else $error("eight-bit result placement wrong");

  property p_ten_steps;
    @(posedge clk) disable iff (!rst_b)
      (q.done && !q.eightBit) |-> (stepCountQ == `ACR_STEPS_10);
  endproperty
  a_ten_steps: assert property (p_ten_steps) // RULE5
    else $error("ten-bit conversion took wrong number of steps");

  property p_eight_steps;
    @(posedge clk) disable iff (!rst_b)
      (q.done && q.eightBit) |->
        (stepCountQ == `ACR_STEPS_8 && q.code[1:0] == 2'h0);
  endproperty
  a_eight_steps: assert property (p_eight_steps) // RULE7
    else $error("eight-bit conversion took wrong number of steps");

  property p_unused_clear;
    @(posedge clk) disable iff (!rst_b)
      (q.done && !q.eightBit) |->
        (q.leftJustify ? (q.result.resultLowByte[5:0] == 6'h00)
                       : (q.result.resultHighByte[7:2] == 6'h00));
  endproperty
  a_unused_clear: assert property (p_unused_clear) // RULE8
    else $error("unused result bits not cleared");

  property p_gain_write;
    @(posedge clk) disable iff (!rst_b)
      (sfrBus.wr && sfrBus.addr == `ACR_CFG_ADDR) |=>
        (cfgOut.inputGainSelect == $past(sfrBus.wdata[0]) &&
         cfgOut.conversionClockDivider == $past(sfrBus.wdata[7:3]));
  endproperty
  a_gain_write: assert property (p_gain_write) // RULE6
    else $error("configuration write not applied");

  property p_mode_latched;
    @(posedge clk) disable iff (!rst_b)
      (q.state == ACR_IDLE && convStart) |=>
        (convBusy && q.eightBit == $past(cfgOut.eightBitResolutionEnable));
  endproperty
  a_mode_latched: assert property (p_mode_latched) // RULE5
    else $error("resolution not captured at start");

endmodule

`default_nettype wire

// ---- inc/acr_consts.svh ----
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

// register placement and reset image
`define ACR_CFG_ADDR 8'hBC
`define ACR_CFG_RESET 8'hF9

// field positions inside the configuration byte
`define ACR_DIV_MSB 7
`define ACR_DIV_LSB 3
`define ACR_LJST_BIT 2
`define ACR_8BIT_BIT 1
`define ACR_GAIN_BIT 0

// approximation sequence
`define ACR_FIRST_TRIAL 10'h200
`define ACR_TOP_BIT 4'h9
`define ACR_LAST_BIT_10 4'h0
`define ACR_LAST_BIT_8 4'h2
`define ACR_STEPS_10 4'hA
`define ACR_STEPS_8 4'h8

`endif

// ---- inc/acr_pkg.sv ----
package acr_pkg;

  typedef struct packed {
    logic [4:0] conversionClockDivider;
    logic leftJustifySelect;
    logic eightBitResolutionEnable;
    logic inputGainSelect;
  } acr_cfg_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acr_sfr_type;

  typedef struct packed {
    logic [7:0] resultHighByte;
    logic [7:0] resultLowByte;
  } acr_result_type;

  typedef enum logic {
    ACR_IDLE,
    ACR_CONVERT
  } acr_state_type;

  typedef struct packed {
    acr_cfg_type cfg;
    logic [7:0] rdata;
    acr_state_type state;
    logic [3:0] bitIdx;
    logic eightBit;
    logic leftJustify;
    logic [9:0] trial;
    logic [9:0] code;
    acr_result_type result;
    logic done;
  } acr_core_type;

  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } acr_div_type;

endpackage

// ---- verification/adc_config_register_bench.sv ----
`timescale 1ns/1ns
`default_nettype none

module adc_config_register_bench
  import acr_pkg::*;
();
  logic clk = 1'b0;
  logic rstB;
  acr_sfr_type sfrBus;
  logic [7:0] sfrRdata;
  acr_cfg_type cfgOut;
  logic convTick;
  logic convStart;
  logic compBit;
  logic [9:0] sarTrial;
  logic convBusy;
  logic convDone;
  acr_result_type result;
  int errCount = 0;
  int samplesChecked = 0;
  int cycles = 0;
  logic [7:0] rd;
  logic [7:0] v;

  acr_config i_acr_config (
    .clk(clk),
    .rst_b(rstB),
    .sfrBus(sfrBus),
    .sfrRdata(sfrRdata),
    .cfgOut(cfgOut),
    .conversionClockTick(convTick),
    .convStart(convStart),
    .compBit(compBit),
    .sarTrial(sarTrial),
    .convBusy(convBusy),
    .convDone(convDone),
    .result(result)
  );

  always #5 clk = ~clk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // a hang is cut short here, well above the fewer than two thousand cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] expRes(logic [9:0] c, logic eight,
                                         logic left);
    if (eight)
      return {c[9:2], 8'h00};
    if (left)
      return {c, 6'h00};
    return {6'h00, c};
  endfunction

  task automatic sfrWr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfrBus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    sfrBus.wr = 1'b0;
  endtask

  task automatic sfrRd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfrBus.addr = a;
    sfrBus.rd = 1'b1;
    @(negedge clk);
    sfrBus.rd = 1'b0;
    d = sfrRdata;
  endtask

  // comparator answers as an ideal input at level tgt would
  task automatic runConv(input logic [4:0] dv, input logic eight,
                         input logic left, input logic [9:0] tgt);
    int cyc;
    int ticks;
    int steps;
    logic [7:0] cfgByte;
    cfgByte = {dv, left, eight, 1'($urandom)};
    sfrWr(8'hBC, cfgByte);
    chk(16'(cfgOut), 16'(cfgByte));
    steps = eight ? 8 : 10;
    cyc = 0;
    ticks = 0;
    convStart = 1'b1;
    do begin
      @(negedge clk);
      cyc++;
      // a second start while busy must be dropped
      convStart = (cyc == 3);
      if (cyc == 1)
        chk(16'(convBusy), 16'h0001);
      // mode change mid-run must not touch the running conversion
      if (cyc == 4)
        sfrBus = '{addr: 8'hBC, wdata: cfgByte ^ 8'h06, wr: 1'b1, rd: 1'b0};
      if (cyc == 5)
        sfrBus.wr = 1'b0;
      ticks += int'(convTick);
      compBit = (tgt >= sarTrial);
    end while (convDone !== 1'b1 && cyc < 400);
    chk(16'(cyc), 16'(steps * (dv + 1) + 2));
    chk(16'(ticks), 16'(steps));
    chk(result, expRes(tgt, eight, left));
    chk(16'(convBusy), 16'h0000);
    compBit = 1'b0;
  endtask

  initial begin
    sfrBus = '0;
    convStart = 1'b0;
    compBit = 1'b0;
    rstB = 1'b0;
    void'($urandom(32'hc6291420));
    repeat (6) @(negedge clk);
    rstB = 1'b1;
    chk(16'(cfgOut), 16'h00F9);
    sfrRd(8'hBC, rd);
    chk(16'(rd), 16'h00F9);
    sfrRd(8'hBD, rd);
    chk(16'(rd), 16'h0000);
    sfrWr(8'h3A, 8'h00);
    chk(16'(cfgOut), 16'h00F9);
    $display("test reset_and_unmapped done");
    repeat (20) begin
      v = 8'($urandom);
      sfrWr(8'hBC, v);
      sfrRd(8'hBC, rd);
      chk(16'(rd), 16'(v));
      @(negedge clk);
      chk(16'(sfrRdata), 16'h0000);
    end
    $display("test register_readback done");
    for (int m = 0; m < 4; m++) begin
      runConv(5'h00, m[1], m[0], 10'h3FF);
      runConv(5'h01, m[1], m[0], 10'h000);
      runConv(5'h02, m[1], m[0], 10'h201);
    end
    runConv(5'h1F, 1'b0, 1'b0, 10'h200);
    $display("test conversion_corners done");
    // random runs keep the divider nonzero, as memory power control needs
    repeat (24)
      runConv(5'($urandom_range(1, 3)), 1'($urandom), 1'($urandom),
              10'($urandom));
    $display("test conversion_random done");
    conclude();
  end
endmodule

`default_nettype wire
